//--- hw/cli_defs.svh
// Purpose: Constants of the 139 264 kbit/s coded-mark-inversion line interface
// Assumes: 200 MHz system clock
// Notes:   Timing counts are derived from the printed figures
`ifndef CLI_DEFS_SVH
`define CLI_DEFS_SVH

// Line rate and unit interval
`define CLI_LINE_RATE_KBPS 139264
`define CLI_RATE_TOL_PPM 15
`define CLI_UI_PS 7180

// System clock
`define CLI_CLK_KHZ 200000
`define CLI_CLK_MHZ 200

// Bit-tick accumulator: width and increment, increment = rate / clock * 2^width
`define CLI_NCO_W 24
`define CLI_NCO_INC ((64'd139264 * 64'd16777216) / 64'd200000)

// Alarm apply and release bound
`define CLI_AIS_DELAY_US 250
`define CLI_AIS_DELAY_CYC (`CLI_AIS_DELAY_US * `CLI_CLK_MHZ)

// Default loss detection: quiet cycles to declare, good symbols to clear
`define CLI_LOS_DET_CYC 2000
`define CLI_LOS_CLR_SYM 1024

// Coded symbol patterns (first half, second half)
`define CLI_SYM_ZERO 2'h1
`define CLI_SYM_BAD 2'h2

`endif

//--- hw/cli_pkg.sv
// Purpose: Types of the coded-mark-inversion line interface
// Assumes: Nothing beyond the constants header
// Notes:   Words carry a data bit and an alarm marker together
package cli_pkg;

    // One line symbol: the two half-interval levels
    typedef struct packed {
        logic first_half;
        logic second_half;
    } cli_sym_t;

    // One received word handed to the path termination
    typedef struct packed {
        logic all_ones_alarm_indication;
        logic data;
    } cli_rx_word_t;

    // Receive signal state, one-hot
    typedef enum logic [1:0] {
        RX_SIGNAL = 2'h1,
        RX_LOST = 2'h2
    } cli_rx_state_t;

endpackage : cli_pkg

//--- hw/cli_line_interface.sv
// Purpose: Coded-mark-inversion encoder, decoder, loss detection and alarm substitution
// Assumes: An external serializer/deserializer moves symbol pairs to and from the coax pair
// Notes:   Line bits are clock enables on clk_sys_i; no second clock domain exists
//
// What this block does
// - Transmit data is converted to coded mark inversion before it leaves for the line.
// - Received symbols are decoded and handed downstream through a two-entry buffer with a valid/ready handshake.
// - Line runs at 139 264 kbit/s; receive tolerates 15 ppm rate deviation.
// - Each transmitted symbol occupies one 7.18 ns unit interval, paced by the bit tick.
// - Loss of signal is detected on the incoming line and flagged as a defect.
// - Within 250 us of loss, output becomes all-ones on a stand-in clock.
// - Within 250 us after loss clears, decoded data resumes.
// - Defect reaches the equipment manager only while supervision is monitored.
`timescale 1ns/1ps
`include "cli_defs.svh"

module cli_line_interface
    import cli_pkg::*;
#(
    parameter int LOS_DET_CYC = `CLI_LOS_DET_CYC,
    parameter int LOS_CLR_SYM = `CLI_LOS_CLR_SYM,
    parameter int AIS_DELAY_CYC = `CLI_AIS_DELAY_CYC
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic tx_valid_i,
    input wire logic tx_data_i,
    output logic tx_ready_o,
    output cli_sym_t tx_sym_o,
    output logic tx_sym_stb_o,
    input wire cli_sym_t line_rx_sym_i,
    input wire logic line_rx_tgl_i,
    output cli_rx_word_t rx_word_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic rx_overrun_o,
    input wire logic supervision_monitored_i,
    output logic supervision_state_o,
    output logic loss_of_signal_defect_o,
    output logic los_report_o
);

    // The increment is worked out in 64 bits and cut to the accumulator width on purpose
    localparam logic [`CLI_NCO_W-1:0] NCO_INC = `CLI_NCO_W'(`CLI_NCO_INC);
    localparam logic [15:0] DET_MAX = 16'(LOS_DET_CYC - 1);
    localparam logic [15:0] CLR_MAX = 16'(LOS_CLR_SYM - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: symbol levels and the deserializer toggle
    logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic tgl_seen_ff, nxt_tgl_seen;
    logic rx_evt;
    cli_sym_t rx_sym;

    // First stage feeds only the second stage
    always_comb begin
        nxt_sync1 = sync1_ff;
        nxt_sync2 = sync2_ff;
        nxt_tgl_seen = tgl_seen_ff;
        if (ce_i) begin
            nxt_sync1 = {line_rx_tgl_i, line_rx_sym_i};
            nxt_sync2 = sync1_ff;
            nxt_tgl_seen = sync2_ff[2];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            tgl_seen_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            tgl_seen_ff <= nxt_tgl_seen;
        end
    end

    // A symbol arrives on each toggle edge; rate offset is absorbed here
    assign rx_evt = ce_i && (sync2_ff[2] != tgl_seen_ff);
    assign rx_sym = cli_sym_t'(sync2_ff[1:0]);

    ////////////////////////////////////////////////////////////////////////////////
    // Bit tick from a phase accumulator; paces transmit and the stand-in clock
    logic [`CLI_NCO_W-1:0] nco_ff, nxt_nco;
    logic tick_ff, nxt_tick;

    // Fractional stepping keeps the mean rate within ppm, at the cost of 5 ns jitter
    always_comb begin
        nxt_nco = nco_ff;
        nxt_tick = 1'b0;
        if (ce_i) begin
            {nxt_tick, nxt_nco} = {1'b0, nco_ff} + {1'b0, NCO_INC};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            nco_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            nco_ff <= nxt_nco;
            tick_ff <= nxt_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit encoder
    cli_sym_t tx_sym_ff, nxt_tx_sym;
    logic tx_stb_ff, nxt_tx_stb;
    logic one_level_ff, nxt_one_level;
    logic tx_bit;

    // One bit taken per tick; an idle source is sent as zeros
    assign tx_ready_o = tick_ff && ce_i;
    assign tx_bit = tx_valid_i && tx_data_i;

    always_comb begin
        nxt_tx_sym = tx_sym_ff;
        nxt_tx_stb = 1'b0;
        nxt_one_level = one_level_ff;
        if (tick_ff && ce_i) begin
            nxt_tx_stb = 1'b1;
            if (tx_bit) begin
                nxt_tx_sym = cli_sym_t'({~one_level_ff, ~one_level_ff});
                nxt_one_level = ~one_level_ff;
            end else begin
                nxt_tx_sym = cli_sym_t'(`CLI_SYM_ZERO);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            tx_sym_ff <= cli_sym_t'(`CLI_SYM_ZERO);
            tx_stb_ff <= 1'b0;
            one_level_ff <= 1'b0;
        end else begin
            tx_sym_ff <= nxt_tx_sym;
            tx_stb_ff <= nxt_tx_stb;
            one_level_ff <= nxt_one_level;
        end
    end

    assign tx_sym_o = tx_sym_ff;
    assign tx_sym_stb_o = tx_stb_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive decoder, loss detection and alarm substitution
    cli_rx_state_t state_ff, nxt_state;
    cli_sym_t prev_sym_ff, nxt_prev_sym;
    logic [15:0] quiet_ff, nxt_quiet;
    logic [15:0] good_ff, nxt_good;
    logic sup_ff, nxt_sup;
    logic ovr_ff, nxt_ovr;
    logic line_active;
    logic push;
    logic push_ready;
    cli_rx_word_t push_word;

    // A dead line shows no level change, within or between symbols
    assign line_active = rx_evt && ((rx_sym != prev_sym_ff) || (rx_sym.first_half != rx_sym.second_half));

    always_comb begin
        nxt_state = state_ff;
        nxt_prev_sym = prev_sym_ff;
        nxt_quiet = quiet_ff;
        nxt_good = good_ff;
        nxt_ovr = ovr_ff;
        nxt_sup = sup_ff;
        push = 1'b0;
        push_word = '0;
        if (ce_i) begin
            nxt_sup = supervision_monitored_i;
            if (rx_evt) begin
                nxt_prev_sym = rx_sym;
            end
            if (line_active) begin
                nxt_quiet = 16'h0000;
            end else if (quiet_ff != DET_MAX) begin
                nxt_quiet = quiet_ff + 16'h0001;
            end
            case (state_ff)
                RX_SIGNAL: begin
                    // Low then high is zero; a flat symbol is one
                    push = rx_evt;
                    push_word.data = (rx_sym != cli_sym_t'(`CLI_SYM_ZERO));
                    if (quiet_ff == DET_MAX) begin
                        nxt_state = RX_LOST;
                        nxt_good = 16'h0000;
                        push = 1'b0;
                    end
                end
                RX_LOST: begin
                    // All-ones on the local tick stands in for the lost clock
                    push = tick_ff;
                    push_word = '{all_ones_alarm_indication: 1'b1, data: 1'b1};
                    if (!line_active && rx_evt) begin
                        nxt_good = 16'h0000;
                    end else if (line_active && good_ff == CLR_MAX) begin
                        nxt_state = RX_SIGNAL;
                    end else if (line_active) begin
                        nxt_good = good_ff + 16'h0001;
                    end
                end
                default: begin
                    nxt_state = RX_LOST;
                end
            endcase
            // The line cannot be stalled, so a full buffer drops the bit
            if (push && !push_ready) begin
                nxt_ovr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_ff <= RX_LOST;
            prev_sym_ff <= cli_sym_t'(2'h0);
            quiet_ff <= 16'h0000;
            good_ff <= 16'h0000;
            ovr_ff <= 1'b0;
            sup_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            prev_sym_ff <= nxt_prev_sym;
            quiet_ff <= nxt_quiet;
            good_ff <= nxt_good;
            ovr_ff <= nxt_ovr;
            sup_ff <= nxt_sup;
        end
    end

    assign loss_of_signal_defect_o = (state_ff == RX_LOST);
    assign los_report_o = (state_ff == RX_LOST) && sup_ff;
    assign supervision_state_o = sup_ff;
    assign rx_overrun_o = ovr_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer toward the path termination
    cli_rx_word_t buf_mem_ff [0:1];
    cli_rx_word_t nxt_mem [0:1];
    logic wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
    logic [1:0] cnt_ff, nxt_cnt;
    logic do_wr, do_rd;

    assign push_ready = (cnt_ff != 2'h2);
    assign do_wr = push && push_ready;
    assign do_rd = ce_i && rx_valid_o && rx_ready_i;

    always_comb begin
        nxt_mem = buf_mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_cnt = cnt_ff;
        if (do_wr) begin
            nxt_mem[wr_ptr_ff] = push_word;
            nxt_wr_ptr = ~wr_ptr_ff;
        end
        if (do_rd) begin
            nxt_rd_ptr = ~rd_ptr_ff;
        end
        nxt_cnt = cnt_ff + {1'b0, do_wr} - {1'b0, do_rd};
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            buf_mem_ff[0] <= '0;
            buf_mem_ff[1] <= '0;
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            buf_mem_ff <= nxt_mem;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff <= nxt_cnt;
        end
    end

    assign rx_valid_o = (cnt_ff != 2'h0);
    assign rx_word_o = buf_mem_ff[rd_ptr_ff];

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_zero_sent;
        tick_ff && ce_i && !tx_bit;
    endsequence

    sequence s_one_sent;
        tick_ff && ce_i && tx_bit;
    endsequence

    a_tx_zero_code: assert property (s_zero_sent |=> tx_sym_o == cli_sym_t'(`CLI_SYM_ZERO) && tx_sym_stb_o)
        else $error("zero not sent as low then high");
    a_tx_one_alt: assert property (s_one_sent |=> tx_sym_o.first_half == tx_sym_o.second_half
        && tx_sym_o.first_half != $past(one_level_ff))
        else $error("one not sent as alternating flat level");
    // The line rate is above half the clock, so ticks may follow back to back but never skip two cycles
    a_tick_rate: assert property (ce_i && $past(ce_i) && !tick_ff && nco_ff != '0 |=> tick_ff)
        else $error("bit tick missing after an idle cycle");
    a_los_entry: assert property (ce_i && state_ff == RX_SIGNAL && quiet_ff == DET_MAX
        |=> loss_of_signal_defect_o)
        else $error("loss not declared after quiet period");
    a_ais_content: assert property (do_wr && state_ff == RX_LOST |=> buf_mem_ff[$past(wr_ptr_ff)] == 2'h3)
        else $error("alarm word not all ones");
    a_ais_clear: assert property (ce_i && state_ff == RX_LOST && line_active && good_ff == CLR_MAX
        |=> !loss_of_signal_defect_o)
        else $error("alarm not released after good symbols");
    a_report_gate: assert property (los_report_o |-> loss_of_signal_defect_o && supervision_state_o)
        else $error("defect reported while not monitored");
    a_sup_readback: assert property (ce_i |=> supervision_state_o == $past(supervision_monitored_i))
        else $error("supervision readback stale");
    a_rx_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_word_o))
        else $error("received word lost under stall");
    a_det_bound: assert property (LOS_DET_CYC <= AIS_DELAY_CYC)
        else $error("loss detection slower than alarm bound");

endmodule : cli_line_interface

//--- tb/cli_line_model.sv
// Purpose: Remote line equipment that sends coded symbols with one toggle per symbol
// Assumes: Changes its outputs just after rising edges; the bench steers it at falling edges
// Notes:   run_i low is a dead coax pair: no transitions at all, so the line rests at 0
`timescale 1ns/1ps

module cli_line_model
    import cli_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic run_i,
    input wire logic zeros_i,
    input wire logic slow_i,
    output cli_sym_t sym_o,
    output logic tgl_o,
    output logic take_o,
    output logic sent_o
);
    logic [3:0] num_ff;
    logic [1:0] gap_ff;
    logic ones_hi_ff;
    logic cur_bit;

    ////////////////////////////////////////////////////////////////////////////////
    // Test pattern; symbol 0 after a run of zeros is always a one, so the bench can align
    assign cur_bit = zeros_i ? 1'b0 : (~(num_ff[0] ^ num_ff[2]) ^ (num_ff[1] & num_ff[3]));

    initial begin
        sym_o = 2'h0;
        tgl_o = 1'b0;
        take_o = 1'b0;
        sent_o = 1'b0;
        num_ff = 4'h0;
        gap_ff = 2'h0;
        ones_hi_ff = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One symbol every two cycles, three when slow; never closer, as the receiver needs
    always @(posedge clk_sys_i) begin
        take_o <= 1'b0;
        if (!run_i) begin
            sym_o <= 2'h0;
        end else if (gap_ff != 2'h0) begin
            gap_ff <= gap_ff - 2'h1;
        end else begin
            gap_ff <= slow_i ? 2'h2 : 2'h1;
            take_o <= 1'b1;
            sent_o <= cur_bit;
            tgl_o <= ~tgl_o;
            num_ff <= zeros_i ? 4'h0 : num_ff + 4'h1;
            if (!cur_bit) begin
                sym_o <= 2'h1;
            end else begin
                sym_o <= ones_hi_ff ? 2'h3 : 2'h0;
                ones_hi_ff <= ~ones_hi_ff;
            end
        end
    end
endmodule : cli_line_model

//--- tb/cli_line_interface_tb.sv
// Purpose: Self-checking bench for the coded line interface
// Assumes: Inputs change at falling edges; short loss counts are used to keep the run brief
// Notes:   Clock enable is tied high; freezing is not exercised
`timescale 1ns/1ps

module cli_line_interface_tb
    import cli_pkg::*;
;
    localparam int DET = 16;
    localparam int CLR = 4;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic tx_valid_i = 1'b0;
    logic tx_data_i = 1'b0;
    logic rx_ready_i = 1'b1;
    logic supervision_monitored_i = 1'b0;
    logic run = 1'b0;
    logic zeros = 1'b1;
    logic slow = 1'b0;
    logic rec = 1'b0;
    logic tx_ready_o, tx_sym_stb_o, rx_valid_o, rx_overrun_o, take, sent, line_tgl;
    logic supervision_state_o, loss_of_signal_defect_o, los_report_o;
    cli_sym_t tx_sym_o, line_sym;
    cli_rx_word_t rx_word_o;
    logic exp_q[$];
    int num_errors = 0;
    int compares = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    cli_line_interface #(.LOS_DET_CYC(DET), .LOS_CLR_SYM(CLR)) dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .tx_valid_i(tx_valid_i),
        .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .tx_sym_o(tx_sym_o), .tx_sym_stb_o(tx_sym_stb_o),
        .line_rx_sym_i(line_sym), .line_rx_tgl_i(line_tgl), .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready_i), .rx_overrun_o(rx_overrun_o), .supervision_monitored_i(supervision_monitored_i),
        .supervision_state_o(supervision_state_o), .loss_of_signal_defect_o(loss_of_signal_defect_o),
        .los_report_o(los_report_o));

    cli_line_model line (.clk_sys_i(clk_sys_i), .run_i(run), .zeros_i(zeros), .slow_i(slow),
        .sym_o(line_sym), .tgl_o(line_tgl), .take_o(take), .sent_o(sent));

    ////////////////////////////////////////////////////////////////////////////////
    // Sent bits are queued from the first one on, so the zero run before it never counts
    always @(negedge clk_sys_i) begin
        if (rec && take === 1'b1 && (exp_q.size() > 0 || sent === 1'b1)) exp_q.push_back(sent);
    end

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : report
    task automatic cmp_flag(input logic got, input logic exp);
        report(32'(got), 32'(exp));
    endtask : cmp_flag
    task automatic cmp_sym(input cli_sym_t got, input cli_sym_t exp);
        report(32'(got), 32'(exp));
    endtask : cmp_sym
    task automatic cmp_word(input cli_rx_word_t got, input cli_rx_word_t exp);
        report(32'(got), 32'(exp));
    endtask : cmp_word
    task automatic cmp_count(input int got, input int lo, input int hi);
        report(32'(got), (got >= lo && got <= hi) ? 32'(got) : 32'(lo));
    endtask : cmp_count

    // Pops one word; ready stays high afterwards, so callers that pause lose words unseen
    task automatic get_word(output cli_rx_word_t w);
        int n;
        n = 0;
        rx_ready_i = 1'b1;
        while (rx_valid_o !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        cmp_count(n, 0, 49);
        w = rx_word_o;
        @(negedge clk_sys_i);
    endtask : get_word

    ////////////////////////////////////////////////////////////////////////////////
    // Values held while reset is still applied
    task automatic t_reset();
        cmp_flag(loss_of_signal_defect_o, 1'b1);
        cmp_flag(los_report_o, 1'b0);
        cmp_flag(supervision_state_o, 1'b0);
        cmp_flag(tx_sym_stb_o, 1'b0);
        cmp_flag(rx_valid_o, 1'b0);
        cmp_flag(rx_overrun_o, 1'b0);
        cmp_sym(tx_sym_o, 2'h1);
    endtask : t_reset

    // Encoding of valid, invalid, zero and one bits, and the tick rate over 2000 cycles
    task automatic t_tx();
        cli_sym_t q[$];
        logic ones_hi, prev;
        int k, ticks;
        ones_hi = 1'b1;
        prev = 1'b0;
        k = 0;
        ticks = 0;
        repeat (2000) begin
            @(negedge clk_sys_i);
            if (tx_sym_stb_o === 1'b1 && q.size() > 0) cmp_sym(tx_sym_o, q.pop_front());
            if (tx_ready_o !== 1'b1 && k > 0) cmp_flag(prev, 1'b1);
            if (tx_ready_o === 1'b1) begin
                ticks++;
                tx_valid_i = (k % 5) != 4;
                tx_data_i = k[0] ^ k[2];
                if (!(tx_valid_i && tx_data_i)) q.push_back(2'h1);
                else q.push_back(ones_hi ? 2'h3 : 2'h0);
                if (tx_valid_i && tx_data_i) ones_hi = ~ones_hi;
                k++;
            end
            prev = tx_ready_o;
        end
        cmp_count(ticks, 2000 * 139264 / 200000, 2000 * 139264 / 200000 + 1);
    endtask : t_tx

    // Dead line from reset: alarm words at the stand-in rate, report gated by supervision
    task automatic t_alarm();
        int n;
        n = 0;
        cmp_flag(loss_of_signal_defect_o, 1'b1);
        cmp_flag(los_report_o, 1'b0);
        repeat (1000) begin
            @(negedge clk_sys_i);
            if (rx_valid_o === 1'b1) begin
                n++;
                cmp_word(rx_word_o, 2'h3);
            end
        end
        cmp_count(n, 1000 * 139264 / 200000 - 1, 1000 * 139264 / 200000 + 1);
        supervision_monitored_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        cmp_flag(supervision_state_o, 1'b1);
        cmp_flag(los_report_o, 1'b1);
    endtask : t_alarm

    // Signal returns: defect clears, then decoded data follows at two symbol rates
    task automatic t_clear();
        cli_rx_word_t w;
        int n;
        n = 0;
        run = 1'b1;
        while (loss_of_signal_defect_o !== 1'b0 && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        cmp_count(n, 2 * CLR, 2 * CLR + 20);
        cmp_flag(los_report_o, 1'b0);
        repeat (20) @(negedge clk_sys_i);
        rec = 1'b1;
        zeros = 1'b0;
        n = 0;
        get_word(w);
        while (w === 2'h0 && n < 20) begin
            get_word(w);
            n++;
        end
        for (int i = 0; i < 40; i++) begin
            if (i == 20) slow = 1'b1;
            if (exp_q.size() == 0) cmp_flag(1'b0, 1'b1);
            else cmp_word(w, {1'b0, exp_q.pop_front()});
            get_word(w);
        end
        rec = 1'b0;
        slow = 1'b0;
    endtask : t_clear

    // Receiver stalls: buffer fills, word stands, overrun flags, then drains to empty
    task automatic t_stall();
        cli_rx_word_t w;
        int n;
        zeros = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        cmp_flag(rx_overrun_o, 1'b0);
        rx_ready_i = 1'b0;
        repeat (20) @(negedge clk_sys_i);
        cmp_flag(rx_overrun_o, 1'b1);
        repeat (8) begin
            @(negedge clk_sys_i);
            cmp_flag(rx_valid_o, 1'b1);
            cmp_word(rx_word_o, 2'h0);
        end
        get_word(w);
        cmp_word(w, 2'h0);
        n = 0;
        while (rx_valid_o !== 1'b0 && n < 8) begin
            @(negedge clk_sys_i);
            n++;
        end
        cmp_count(n, 0, 4);
    endtask : t_stall

    // Line dies mid-stream: defect, report, alarm words; report drops when unmonitored
    task automatic t_loss();
        cli_rx_word_t w;
        int n;
        n = 0;
        run = 1'b0;
        while (loss_of_signal_defect_o !== 1'b1 && n < DET + 40) begin
            @(negedge clk_sys_i);
            n++;
        end
        cmp_count(n, DET, DET + 12);
        cmp_flag(los_report_o, 1'b1);
        n = 0;
        get_word(w);
        while (w !== 2'h3 && n < 8) begin
            get_word(w);
            n++;
        end
        get_word(w);
        cmp_word(w, 2'h3);
        supervision_monitored_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        cmp_flag(supervision_state_o, 1'b0);
        cmp_flag(los_report_o, 1'b0);
    endtask : t_loss

    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the watchdog allows about six times the expected run
    initial begin
        repeat (20) @(negedge clk_sys_i);
        t_reset();
        sys_rst_i = 1'b0;
        t_tx();
        t_alarm();
        t_clear();
        t_stall();
        t_loss();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        test_done();
    end
endmodule : cli_line_interface_tb
